// [verilog/agp_pm_capability_regs.v]
`timescale 1ns/1ps
`include "cap_regs_defines.vh"

module agp_pm_capability_regs #(
	parameter [7:0] MAX_REQUESTS = 8'h20
) (
	input  wire        i_clk_sys,
	input  wire        i_rstn,
	input  wire [11:0] i_cfg_addr,
	input  wire        i_cfg_wr,
	input  wire        i_cfg_rd,
	input  wire [3:0]  i_cfg_be,
	input  wire [31:0] i_cfg_wdata,
	output reg  [31:0] o_cfg_rdata,
	input  wire        i_wake_event,
	input  wire        i_req_issue,
	input  wire        i_req_retire,
	output wire        o_req_may_issue,
	output wire [7:0]  o_req_outstanding,
	output wire [7:0]  o_request_queue_limit,
	output wire        o_sideband_addressing_on,
	output wire        o_graphics_port_on,
	output wire [2:0]  o_data_rate,
	output wire [1:0]  o_power_state,
	output wire        o_wake_event_enable,
	output wire        o_wake_request
);
	// ********************************************************
	// writable state
	// ********************************************************
	reg [7:0] limit_reg;
	reg       sideband_reg;
	reg       port_on_reg;
	reg       above_4g_reg;
	reg       fast_write_reg;
	reg [2:0] rate_reg;
	reg       wake_status_reg;
	reg [3:0] select_reg;
	reg       wake_enable_reg;
	reg [1:0] state_reg;

	wire wr_cmd;
	wire wr_pcs;
	wire wake_clear;

	assign wr_cmd = i_cfg_wr & (i_cfg_addr == `OFS_GP_COMMAND_WORD);
	assign wr_pcs = i_cfg_wr & (i_cfg_addr == `OFS_POWER_CTL_STATUS);
	// status is write-one-to-clear, as the bus convention has it
	assign wake_clear = wr_pcs & i_cfg_be[1]
		& i_cfg_wdata[`PCS_WAKE_STATUS_BIT];

	always @(posedge i_clk_sys) begin
		if (!i_rstn) begin
			limit_reg       <= 8'h00;
			sideband_reg    <= 1'b0;
			port_on_reg     <= 1'b0;
			above_4g_reg    <= 1'b0;
			fast_write_reg  <= 1'b0;
			rate_reg        <= 3'h0;
			wake_status_reg <= 1'b0;
			select_reg      <= 4'h0;
			wake_enable_reg <= 1'b0;
			state_reg       <= 2'h0;
		end else begin
			if (wr_cmd && i_cfg_be[3])
				limit_reg <= i_cfg_wdata[`CMD_LIMIT_HI:`CMD_LIMIT_LO];
			if (wr_cmd && i_cfg_be[1]) begin
				sideband_reg <= i_cfg_wdata[`CMD_SIDEBAND_BIT];
				port_on_reg  <= i_cfg_wdata[`CMD_PORT_ON_BIT];
			end
			if (wr_cmd && i_cfg_be[0]) begin
				above_4g_reg   <= i_cfg_wdata[`CMD_ABOVE_4G_BIT];
				fast_write_reg <= i_cfg_wdata[`CMD_FAST_WRITE_BIT];
				rate_reg <= i_cfg_wdata[`CMD_RATE_HI:`CMD_RATE_LO];
			end
			if (wr_pcs && i_cfg_be[1]) begin
				select_reg <= i_cfg_wdata[`PCS_SELECT_HI:`PCS_SELECT_LO];
				wake_enable_reg <= i_cfg_wdata[`PCS_WAKE_ENABLE_BIT];
			end
			if (wr_pcs && i_cfg_be[0])
				state_reg <= i_cfg_wdata[`PCS_STATE_HI:`PCS_STATE_LO];
			// a new event beats a clear in the same cycle
			if (i_wake_event)
				wake_status_reg <= 1'b1;
			else if (wake_clear)
				wake_status_reg <= 1'b0;
		end
	end

	// ********************************************************
	// register words
	// ********************************************************
	wire [31:0] cap_ptr_word;
	wire [31:0] gp_header_word;
	wire [31:0] gp_status_word;
	wire [31:0] gp_command_word;
	wire [31:0] pm_cap_word;
	wire [31:0] pm_ctl_word;

	assign cap_ptr_word = {24'h000000, `CAP_LIST_START};
	assign gp_header_word = {8'h00, `GP_MAJOR_REV, `GP_MINOR_REV,
		`GP_NEXT_POINTER, `GP_CAPABILITY_IDENTIFIER};
	assign gp_status_word = {MAX_REQUESTS, 14'h0000,
		1'b1, 3'h0,
		1'b0, 1'b0,
		1'b0, `GP_RATE_SUPPORT};
	assign gp_command_word = {limit_reg, 14'h0000, sideband_reg,
		port_on_reg, 2'h0, above_4g_reg, fast_write_reg, 1'b0,
		rate_reg};
	assign pm_cap_word = {`PM_WAKE_STATES,
		1'b1, 1'b1,
		3'h0, 1'b0, 1'b0, 1'b1,
		`PM_VERSION,
		`PM_NEXT_POINTER, `PM_CAPABILITY_IDENTIFIER};
	assign pm_ctl_word = {8'h00, 8'h00, wake_status_reg, 2'h0,
		select_reg, wake_enable_reg,
		6'h00,
		state_reg};

	// ********************************************************
	// read path
	// ********************************************************
	// registered read data, one cycle after the read strobe
	reg [31:0] rdata_next;
	always @* begin
		case (i_cfg_addr)
		`OFS_CAP_LIST_POINTER: rdata_next = cap_ptr_word;
		`OFS_GP_CAP_HEADER:    rdata_next = gp_header_word;
		`OFS_GP_STATUS_WORD:   rdata_next = gp_status_word;
		`OFS_GP_COMMAND_WORD:  rdata_next = gp_command_word;
		`OFS_POWER_CAP_WORD:   rdata_next = pm_cap_word;
		`OFS_POWER_CTL_STATUS: rdata_next = pm_ctl_word;
		default:               rdata_next = 32'h00000000;
		endcase
	end

	always @(posedge i_clk_sys) begin
		if (!i_rstn)
			o_cfg_rdata <= 32'h00000000;
		else if (i_cfg_rd)
			o_cfg_rdata <= rdata_next;
	end

	// ********************************************************
	// request limit and outputs
	// ********************************************************
	// only issues with the port enabled are counted; o_req_may_issue ignores the port
	request_limiter #(
		.WIDTH(8)
	) i_request_limiter (
		.i_clk_sys     (i_clk_sys),
		.i_rstn        (i_rstn),
		.i_limit       (limit_reg),
		.i_issue       (i_req_issue & port_on_reg),
		.i_retire      (i_req_retire),
		.o_may_issue   (o_req_may_issue),
		.o_outstanding (o_req_outstanding)
	);

	assign o_request_queue_limit    = limit_reg;
	assign o_sideband_addressing_on = sideband_reg;
	assign o_graphics_port_on       = port_on_reg;
	assign o_data_rate              = rate_reg;
	assign o_power_state            = state_reg;
	assign o_wake_event_enable      = wake_enable_reg;
	assign o_wake_request = wake_status_reg & wake_enable_reg;
endmodule // agp_pm_capability_regs

// [verilog/cap_regs_defines.vh]
`ifndef CAP_REGS_DEFINES_VH
`define CAP_REGS_DEFINES_VH

// ********************************************************
// register offsets
// ********************************************************
`define OFS_CAP_LIST_POINTER    12'hf34
`define OFS_GP_CAP_HEADER       12'hf80
`define OFS_GP_STATUS_WORD      12'hf84
`define OFS_GP_COMMAND_WORD     12'hf88
`define OFS_POWER_CAP_WORD      12'hfa0
`define OFS_POWER_CTL_STATUS    12'hfa4

// ********************************************************
// constant field values
// ********************************************************
`define CAP_LIST_START          8'h80
`define GP_CAPABILITY_IDENTIFIER               8'h02
`define GP_NEXT_POINTER         8'ha0
`define GP_MAJOR_REV            4'h2
`define GP_MINOR_REV            4'h0
`define GP_RATE_SUPPORT         3'h3
`define PM_CAPABILITY_IDENTIFIER               8'h01
`define PM_NEXT_POINTER         8'h00
`define PM_WAKE_STATES          5'h0f
`define PM_VERSION              3'h1

// ********************************************************
// writable field positions
// ********************************************************
`define CMD_LIMIT_HI            31
`define CMD_LIMIT_LO            24
`define CMD_SIDEBAND_BIT        9
`define CMD_PORT_ON_BIT         8
`define CMD_ABOVE_4G_BIT        5
`define CMD_FAST_WRITE_BIT      4
`define CMD_RATE_HI             2
`define CMD_RATE_LO             0
`define PCS_WAKE_STATUS_BIT     15
`define PCS_SELECT_HI           12
`define PCS_SELECT_LO           9
`define PCS_WAKE_ENABLE_BIT     8
`define PCS_STATE_HI            1
`define PCS_STATE_LO            0

`endif

// [verilog/request_limiter.v]
`timescale 1ns/1ps
// ********************************************************
// outstanding request counter held under a programmed limit
// ********************************************************
module request_limiter #(
	parameter WIDTH = 8
) (
	input  wire             i_clk_sys,
	input  wire             i_rstn,
	input  wire [WIDTH-1:0] i_limit,
	input  wire             i_issue,
	input  wire             i_retire,
	output wire             o_may_issue,
	output reg  [WIDTH-1:0] o_outstanding
);
	reg [WIDTH-1:0] count_next;
	wire            issue_ok;

	// a limit of zero blocks all requests
	assign o_may_issue = (o_outstanding < i_limit);
	assign issue_ok    = i_issue & o_may_issue;

	always @* begin
		count_next = o_outstanding;
		if (issue_ok && !(i_retire && o_outstanding != {WIDTH{1'b0}}))
			count_next = o_outstanding + 1'b1;
		else if (!issue_ok && i_retire && o_outstanding != {WIDTH{1'b0}})
			count_next = o_outstanding - 1'b1;
	end

	always @(posedge i_clk_sys) begin
		if (!i_rstn)
			o_outstanding <= {WIDTH{1'b0}};
		else
			o_outstanding <= count_next;
	end
endmodule // request_limiter

// [verification/cap_regs_chk.sv]
`timescale 1ns/1ps
// ****************************************
// register bank checker
// ****************************************
module cap_regs_chk #(
	parameter [7:0] MAX_REQUESTS = 8'h20
) (
	input wire        i_clk_sys,
	input wire        i_rstn,
	input wire [11:0] i_cfg_addr,
	input wire        i_cfg_wr,
	input wire        i_cfg_rd,
	input wire [3:0]  i_cfg_be,
	input wire [31:0] i_cfg_wdata,
	input wire [31:0] o_cfg_rdata,
	input wire        o_req_may_issue,
	input wire [7:0]  o_req_outstanding,
	input wire [7:0]  o_request_queue_limit,
	input wire        o_graphics_port_on,
	input wire [1:0]  o_power_state,
	input wire        o_wake_event_enable,
	input wire        o_wake_request
);
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	sequence s_rd(logic [11:0] a);
		i_cfg_rd && i_cfg_addr == a;
	endsequence
	sequence s_lim_wr;
		i_cfg_wr && i_cfg_addr == 12'hf88 && i_cfg_be[3];
	endsequence
	chk_list_pointer: assert property (s_rd(12'hf34) |=>
		o_cfg_rdata == 32'h00000080) else $error("pointer read");
	chk_port_header: assert property (s_rd(12'hf80) |=>
		o_cfg_rdata == 32'h0020a002) else $error("header read");
	chk_port_status: assert property (s_rd(12'hf84) |=>
		o_cfg_rdata == {MAX_REQUESTS, 24'h000203}) else $error("status");
	chk_power_cap: assert property (s_rd(12'hfa0) |=>
		o_cfg_rdata == 32'h7e090001) else $error("power cap read");
	chk_ctl_reserved: assert property (s_rd(12'hfa4) |=>
		o_cfg_rdata[7:2] == 6'h00) else $error("reserved bits set");
	chk_limit_write: assert property (s_lim_wr |=>
		{o_request_queue_limit, 24'h000000} ==
		($past(i_cfg_wdata) & 32'hff000000)) else $error("limit write");
	chk_limit_kept: assert property (!o_req_may_issue |=>
		o_req_outstanding <= $past(o_req_outstanding))
		else $error("count rose at limit");
	chk_wake_gate: assert property (o_wake_request |->
		o_wake_event_enable) else $error("wake while disabled");
	chk_reset_clear: assert property (disable iff (1'b0) !i_rstn |=>
		!o_graphics_port_on && o_power_state == 2'h0 &&
		!o_wake_event_enable) else $error("reset values");
endmodule // cap_regs_chk

bind agp_pm_capability_regs cap_regs_chk #(
	.MAX_REQUESTS(MAX_REQUESTS)
) i_cap_regs_chk (.*);

// [verification/host_cfg_model.sv]
`timescale 1ns/1ps
// ****************************************
// host configuration access model
// ****************************************
module host_cfg_model (
	input  wire         i_clk_sys,
	input  wire  [31:0] i_cfg_rdata,
	output logic [11:0] o_cfg_addr = 12'h000,
	output logic        o_cfg_wr = 1'b0,
	output logic        o_cfg_rd = 1'b0,
	output logic [3:0]  o_cfg_be = 4'h0,
	output logic [31:0] o_cfg_wdata = 32'h0
);
	// write data and read address flip on release so stale values never look valid
	task automatic wr(input [11:0] a, input [3:0] b, input [31:0] d);
		@(posedge i_clk_sys);
		#1;
		o_cfg_addr = a;
		o_cfg_be = b;
		o_cfg_wdata = d;
		o_cfg_wr = 1'b1;
		@(posedge i_clk_sys);
		#1;
		o_cfg_wr = 1'b0;
		o_cfg_wdata = ~d;
	endtask
	task automatic rd(input [11:0] a, output [31:0] d);
		@(posedge i_clk_sys);
		#1;
		o_cfg_addr = a;
		o_cfg_rd = 1'b1;
		@(posedge i_clk_sys);
		#1;
		o_cfg_rd = 1'b0;
		o_cfg_addr = ~a;
		d = i_cfg_rdata;
	endtask
endmodule // host_cfg_model

// [verification/tb_agp_pm_capability_regs.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
	$display("BAD %0t got %h", $time, a); end end
module tb_agp_pm_capability_regs;
	logic        i_clk_sys = 1'b0;
	logic        i_rstn = 1'b0;
	logic        wake = 1'b0;
	logic        issue = 1'b0;
	logic        retire = 1'b0;
	logic [31:0] d;
	int          checks = 0;
	int          miscompares = 0;
	int          cycles = 0;
	wire  [11:0] addr;
	wire  [31:0] wdata, rdata;
	wire  [3:0]  be;
	wire  [7:0]  outst, limit;
	wire  [2:0]  rate;
	wire  [1:0]  state;
	wire         wr, rd, may, sb, on, wen, wreq;
	always #10 i_clk_sys = ~i_clk_sys;
	host_cfg_model i_host_cfg_model (.i_clk_sys(i_clk_sys),
		.i_cfg_rdata(rdata), .o_cfg_addr(addr), .o_cfg_wr(wr),
		.o_cfg_rd(rd), .o_cfg_be(be), .o_cfg_wdata(wdata));
	agp_pm_capability_regs i_agp_pm_capability_regs (.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn), .i_cfg_addr(addr), .i_cfg_wr(wr), .i_cfg_rd(rd),
		.i_cfg_be(be), .i_cfg_wdata(wdata), .o_cfg_rdata(rdata),
		.i_wake_event(wake), .i_req_issue(issue), .i_req_retire(retire),
		.o_req_may_issue(may), .o_req_outstanding(outst),
		.o_request_queue_limit(limit), .o_sideband_addressing_on(sb),
		.o_graphics_port_on(on), .o_data_rate(rate),
		.o_power_state(state), .o_wake_event_enable(wen),
		.o_wake_request(wreq));
	task summarize;
		if (miscompares == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	always @(posedge i_clk_sys) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			summarize();
		end
	end
	task t_reset_values;
		`CHK(may, 1'b0)
		i_host_cfg_model.rd(12'hf88, d);
		`CHK(d, 32'h0)
		i_host_cfg_model.rd(12'hfa4, d);
		`CHK(d, 32'h0)
	endtask
	task t_constants;
		i_host_cfg_model.rd(12'hf34, d);
		`CHK(d, 32'h00000080)
		i_host_cfg_model.rd(12'hf80, d);
		`CHK(d, 32'h0020a002)
		i_host_cfg_model.rd(12'hf84, d);
		`CHK(d, 32'h20000203)
		i_host_cfg_model.rd(12'hfa0, d);
		`CHK(d, 32'h7e090001)
		i_host_cfg_model.rd(12'hf38, d);
		`CHK(d, 32'h0)
	endtask
	task t_command;
		i_host_cfg_model.wr(12'hf88, 4'hf, 32'h02000333);
		i_host_cfg_model.wr(12'hf88, 4'h7, 32'hff000333);
		i_host_cfg_model.rd(12'hf88, d);
		`CHK(d, 32'h02000333)
		`CHK({limit, sb, on, rate}, 13'h005b)
	endtask
	// issue held high three cycles against a limit of two
	task t_limit;
		@(posedge i_clk_sys);
		#1 issue = 1'b1;
		repeat (3) @(posedge i_clk_sys);
		#1 issue = 1'b0;
		`CHK({outst, may}, 9'h004)
		retire = 1'b1;
		@(posedge i_clk_sys);
		#1 retire = 1'b0;
		`CHK({outst, may}, 9'h003)
	endtask
	task t_power;
		for (int s = 0; s < 4; s++) begin
			i_host_cfg_model.wr(12'hfa4, 4'hf, 32'hfffffffc | s);
			`CHK(state, s[1:0])
		end
		i_host_cfg_model.rd(12'hfa4, d);
		`CHK(d, 32'h00001f03)
		`CHK(wen, 1'b1)
		wake = 1'b1;
		@(posedge i_clk_sys);
		#1 wake = 1'b0;
		`CHK(wreq, 1'b1)
		i_host_cfg_model.wr(12'hfa4, 4'h2, 32'h00009f00);
		i_host_cfg_model.rd(12'hfa4, d);
		`CHK({d, wreq}, 33'h000003e06)
	endtask
	initial begin
		repeat (6) @(posedge i_clk_sys);
		#1 i_rstn = 1'b1;
		t_reset_values();
		t_constants();
		t_command();
		t_limit();
		t_power();
		summarize();
	end
endmodule // tb_agp_pm_capability_regs
